// ===== hw/ihc_host_ctrl.sv
// Host bus controller: configuration registers, a bit-level host engine
// for the external memory and temperature sensors, and reading averagers.
// Assumes open-drain pins resolved outside, one clock, same-domain strobes.
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// Averager of the last one, two or four readings
// --------------------------------------------------------------------------
module ihc_avg #(
   parameter int W = 8
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic valid_in,
   input wire logic [W-1:0] data_in,
   input wire logic [1:0] mode_in,
   output logic [W-1:0] avg_out
);
   logic [W-1:0] hist_r [0:2];
   logic [W:0] sum2_w;
   logic [W+1:0] sum4_w;
   logic [W-1:0] avg_nxt;

   // Sums include the incoming reading so the average is ready with it.
   assign sum2_w = {1'b0, data_in} + {1'b0, hist_r[0]};
   assign sum4_w = {1'b0, sum2_w} + {2'b00, hist_r[1]} + {2'b00, hist_r[2]};
   assign avg_nxt = (mode_in == ihc_pkg::AVG_TWO) ? sum2_w[W:1] :
                    (mode_in == ihc_pkg::AVG_FOUR) ? sum4_w[W+1:2] : data_in;

   // History shift and registered average; the invalid code averages nothing.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < 3; i++) begin
            hist_r[i] <= '0;
         end
         avg_out <= '0;
      end else if (valid_in) begin
         hist_r[0] <= data_in;
         for (int i = 1; i < 3; i++) begin
            hist_r[i] <= hist_r[i-1];
         end
         avg_out <= avg_nxt;
      end
   end
endmodule

// --------------------------------------------------------------------------
// Top of the host bus controller
// --------------------------------------------------------------------------
module ihc_host_ctrl #(
   parameter int QTR_CYC = ihc_pkg::QTR_CYC
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [23:0] reg_wdata_in,
   output logic [23:0] reg_rdata_out,
   input wire logic sample_start_in,
   input wire logic [1:0] emitter_channel_in,
   input wire logic init_load_done_in,
   input wire logic onchip_temp_valid_in,
   input wire logic [7:0] onchip_temp_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe_out,
   output logic sda_out,
   output logic sda_oe_out,
   output logic [7:0] ext_temp_avg_out,
   output logic [7:0] onchip_temp_avg_out,
   output logic host_busy_out,
   output logic host_nack_out
);
   // Refuses a quarter-bit count that the 16-bit timer or the synchroniser cannot serve.
   if (QTR_CYC < 2 || QTR_CYC > 65535) begin : g_bad_qtr
      $error("QTR_CYC out of range");
   end

   // -----------------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------------
   logic [23:0] ctrl_r, tcfg_r, stat_r, rdata_w;
   logic [7:0] rdat_r;
   logic wr_ctrl_w, wr_tcfg_w, wr_stat_w;

   assign wr_ctrl_w = reg_wr_in && (reg_addr_in == ihc_pkg::OFS_HOST_CTRL);
   assign wr_tcfg_w = reg_wr_in && (reg_addr_in == ihc_pkg::OFS_TS_CFG);
   assign wr_stat_w = reg_wr_in && (reg_addr_in == ihc_pkg::OFS_STATUS);

   // Status reads live load flag and held read data; unmapped offsets read 0.
   assign rdata_w = (reg_addr_in == ihc_pkg::OFS_HOST_CTRL) ? ctrl_r :
                    (reg_addr_in == ihc_pkg::OFS_TS_CFG) ? tcfg_r :
                    (reg_addr_in == ihc_pkg::OFS_STATUS) ?
                    (stat_r | (24'(init_load_done_in) << ihc_pkg::ILD_BIT) |
                     (24'(rdat_r) << ihc_pkg::RDAT_LSB)) : 24'h000000;

   // Field decode.
   logic [1:0] rw_w, tavg_w, mavg_w, chan_w;
   logic en_w, trig_w, psel_w, swap_w, tren_w, ntran_w;
   logic [6:0] eep_w, ts_w;
   logic [7:0] sra_w;
   assign rw_w = ctrl_r[ihc_pkg::RW_LSB +: 2];
   assign en_w = ctrl_r[ihc_pkg::EN_BIT];
   assign trig_w = ctrl_r[ihc_pkg::TRIG_BIT];
   assign psel_w = ctrl_r[ihc_pkg::PSEL_BIT];
   assign eep_w = ctrl_r[ihc_pkg::EEP_LSB +: 7];
   assign swap_w = ctrl_r[ihc_pkg::SWAP_BIT];
   assign tavg_w = tcfg_r[ihc_pkg::TAVG_LSB +: 2];
   assign tren_w = tcfg_r[ihc_pkg::TREN_BIT];
   assign mavg_w = stat_r[ihc_pkg::MAVG_LSB +: 2];
   assign ntran_w = stat_r[ihc_pkg::NTRAN_BIT];
   assign sra_w = stat_r[ihc_pkg::SRA_LSB +: 8];
   assign chan_w = emitter_channel_in;
   // Sensor address follows the emitter channel now being driven.
   assign ts_w = (chan_w == 2'h2) ? tcfg_r[ihc_pkg::TS2_LSB +: 7] :
                 (chan_w == 2'h1) ? tcfg_r[ihc_pkg::TS1_LSB +: 7] :
                 tcfg_r[ihc_pkg::TS0_LSB +: 7];

   // -----------------------------------------------------------------------
   // Host engine sequencing
   // -----------------------------------------------------------------------
   ihc_pkg::ihc_state_t st_r;
   logic [15:0] qcnt_r;
   logic [1:0] ph_r;
   logic [3:0] bitn_r;
   logic byten_r, idx_r, nack_r, sda_m_r, sda_s_r;
   logic [7:0] rx_r;
   logic tick_w, launch_w, rd_w, end_ph2_w, end_ph3_w, rx_done_w, ack_bad_w;
   logic [7:0] txb_w, rx_fix_w, rx_rev_w;
   logic tx_bit_w, drive_w, scl_lo_w, sda_lo_w;

   // Trigger source: per-sample strobe or software bit, only while enabled.
   assign launch_w = (st_r == ihc_pkg::ST_IDLE) && en_w &&
                     (psel_w ? sample_start_in : trig_w);
   assign tick_w = (st_r != ihc_pkg::ST_IDLE) && (qcnt_r == 16'(QTR_CYC - 1));
   assign end_ph2_w = tick_w && (ph_r == 2'h2);
   assign end_ph3_w = tick_w && (ph_r == 2'h3);
   assign rd_w = rw_w[idx_r];
   // Address byte then start register address or received byte.
   assign txb_w = byten_r ? sra_w :
                  {(tren_w ? ts_w : eep_w), rd_w};
   assign tx_bit_w = txb_w[3'(7 - bitn_r[2:0])];
   assign drive_w = (bitn_r < 4'h8) && !(byten_r && rd_w);
   assign rx_done_w = end_ph3_w && (st_r == ihc_pkg::ST_BYTE) && byten_r && rd_w &&
                      (bitn_r == 4'h8);
   assign ack_bad_w = end_ph2_w && (st_r == ihc_pkg::ST_BYTE) && (bitn_r == 4'h8) &&
                      !(byten_r && rd_w) && sda_s_r;
   assign rx_rev_w = {<<{rx_r}};
   assign rx_fix_w = swap_w ? rx_rev_w : rx_r;

   // Open-drain levels for each state and quarter of the bit.
   assign scl_lo_w = (st_r == ihc_pkg::ST_START) ? (ph_r >= 2'h2) :
                     (st_r == ihc_pkg::ST_BYTE) ? (ph_r == 2'h0 || ph_r == 2'h3) :
                     (st_r == ihc_pkg::ST_STOP) ? (ph_r == 2'h0) : 1'b0;
   assign sda_lo_w = (st_r == ihc_pkg::ST_START) ? (ph_r != 2'h0) :
                     (st_r == ihc_pkg::ST_BYTE) ? (drive_w && !tx_bit_w) :
                     (st_r == ihc_pkg::ST_STOP) ? (ph_r <= 2'h1) : 1'b0;

   // Registers; a software write wins over the trigger's own clear.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_r <= ihc_pkg::RST_HOST_CTRL;
         tcfg_r <= ihc_pkg::RST_TS_CFG;
         stat_r <= ihc_pkg::RST_STATUS;
         reg_rdata_out <= 24'h000000;
      end else begin
         if (launch_w && !psel_w) begin
            ctrl_r[ihc_pkg::TRIG_BIT] <= 1'b0;
         end
         if (wr_ctrl_w) begin
            ctrl_r <= reg_wdata_in & ihc_pkg::WMASK_HOST_CTRL;
         end
         if (wr_tcfg_w) begin
            tcfg_r <= reg_wdata_in & ihc_pkg::WMASK_TS_CFG;
         end
         if (wr_stat_w) begin
            stat_r <= reg_wdata_in & ihc_pkg::WMASK_STATUS;
         end
         reg_rdata_out <= rdata_w;
      end
   end

   // Quarter-bit timer and phase.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         qcnt_r <= 16'h0000;
         ph_r <= 2'h0;
      end else if (st_r == ihc_pkg::ST_IDLE || tick_w) begin
         qcnt_r <= 16'h0000;
         ph_r <= (st_r == ihc_pkg::ST_IDLE) ? 2'h0 : ph_r + 2'h1;
      end else begin
         qcnt_r <= qcnt_r + 16'h0001;
      end
   end

   // Frame sequencing: start, address byte, second byte, stop.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r <= ihc_pkg::ST_IDLE;
         bitn_r <= 4'h0;
         byten_r <= 1'b0;
         idx_r <= 1'b0;
         nack_r <= 1'b0;
      end else begin
         case (st_r)
            ihc_pkg::ST_IDLE: begin
               if (launch_w) begin
                  st_r <= ihc_pkg::ST_START;
                  idx_r <= 1'b0;
                  nack_r <= 1'b0;
               end
            end
            ihc_pkg::ST_START: begin
               if (end_ph3_w) begin
                  st_r <= ihc_pkg::ST_BYTE;
                  bitn_r <= 4'h0;
                  byten_r <= 1'b0;
               end
            end
            ihc_pkg::ST_BYTE: begin
               if (ack_bad_w) begin
                  nack_r <= 1'b1;
               end
               if (end_ph3_w) begin
                  if (bitn_r != 4'h8) begin
                     bitn_r <= bitn_r + 4'h1;
                  end else if (nack_r || byten_r) begin
                     st_r <= ihc_pkg::ST_STOP;
                  end else begin
                     byten_r <= 1'b1;
                     bitn_r <= 4'h0;
                  end
               end
            end
            ihc_pkg::ST_STOP: begin
               if (end_ph3_w) begin
                  if (ntran_w && !idx_r) begin
                     st_r <= ihc_pkg::ST_START;
                     idx_r <= 1'b1;
                  end else begin
                     st_r <= ihc_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               st_r <= ihc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Pin synchroniser, receive shifter, held read data and pin drivers.
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         rx_r <= 8'h00;
         rdat_r <= 8'h00;
         scl_oe_out <= 1'b0;
         sda_oe_out <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         host_busy_out <= 1'b0;
         host_nack_out <= 1'b0;
      end else begin
         sda_m_r <= sda_in;
         sda_s_r <= sda_m_r;
         if (end_ph2_w && st_r == ihc_pkg::ST_BYTE && byten_r && rd_w && bitn_r < 4'h8) begin
            rx_r <= {rx_r[6:0], sda_s_r};
         end
         if (rx_done_w) begin
            rdat_r <= rx_fix_w;
         end
         scl_oe_out <= scl_lo_w;
         sda_oe_out <= sda_lo_w;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         host_busy_out <= (st_r != ihc_pkg::ST_IDLE);
         host_nack_out <= nack_r;
      end
   end

   // -----------------------------------------------------------------------
   // Temperature averaging
   // -----------------------------------------------------------------------
   ihc_avg #(.W(8)) u_ext_avg (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .valid_in(rx_done_w && tren_w),
      .data_in(rx_fix_w),
      .mode_in(tavg_w),
      .avg_out(ext_temp_avg_out)
   );

   ihc_avg #(.W(8)) u_chip_avg (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .valid_in(onchip_temp_valid_in),
      .data_in(onchip_temp_in),
      .mode_in(mavg_w),
      .avg_out(onchip_temp_avg_out)
   );

   // -----------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_addr_q1;
      st_r == ihc_pkg::ST_BYTE && !byten_r && ph_r == 2'h1;
   endsequence
   sequence s_idle_go;
      st_r == ihc_pkg::ST_IDLE && en_w;
   endsequence

   AST_DIR_BIT: assert property (s_addr_q1 ##0 bitn_r == 4'h7 |=>
      sda_oe_out == !rw_w[idx_r]) else $error("direction bit differs from field");
   AST_NO_RUN_OFF: assert property (st_r == ihc_pkg::ST_IDLE && !en_w |=>
      st_r == ihc_pkg::ST_IDLE) else $error("engine left idle while disabled");
   AST_SW_TRIG: assert property (s_idle_go ##0 (!psel_w && trig_w) |=>
      st_r == ihc_pkg::ST_START ##0 !trig_w) else $error("software trigger lost");
   AST_SAMPLE_TRIG: assert property (s_idle_go ##0 (psel_w && sample_start_in) |=>
      st_r == ihc_pkg::ST_START) else $error("sample start not taken");
   AST_MEM_ADDR: assert property (s_addr_q1 ##0 (!tren_w && bitn_r < 4'h7) |=>
      sda_oe_out == !eep_w[3'(6 - bitn_r)]) else $error("memory address wrong");
   AST_SWAP: assert property (rx_done_w && swap_w |=> rdat_r[0] == $past(rx_r[7]) &&
      rdat_r[7] == $past(rx_r[0])) else $error("swap not applied");
   AST_SENSOR_ADDR: assert property (s_addr_q1 ##0 (tren_w && bitn_r < 4'h7) |=>
      sda_oe_out == !ts_w[3'(6 - bitn_r)]) else $error("sensor address not used");
   AST_CHAN_ADDR: assert property (s_addr_q1 ##0 (tren_w && chan_w == 2'h1 &&
      bitn_r < 4'h7) |=> sda_oe_out == !tcfg_r[ihc_pkg::TS1_LSB + 6 - int'(bitn_r)])
      else $error("channel address wrong");
   AST_EXT_NOAVG: assert property (rx_done_w && tren_w && tavg_w == ihc_pkg::AVG_NONE
      |=> ext_temp_avg_out == $past(rx_fix_w)) else $error("external average wrong");
   AST_CHIP_NOAVG: assert property (onchip_temp_valid_in && mavg_w == ihc_pkg::AVG_NONE
      |=> onchip_temp_avg_out == $past(onchip_temp_in)) else $error("chip average wrong");
   AST_TWO_TRAN: assert property (st_r == ihc_pkg::ST_STOP && end_ph3_w && ntran_w &&
      !idx_r |=> st_r == ihc_pkg::ST_START && idx_r) else $error("second transaction missed");
   AST_SRA_BYTE: assert property (st_r == ihc_pkg::ST_BYTE && byten_r && !rd_w &&
      ph_r == 2'h1 && bitn_r < 4'h8 |=> sda_oe_out == !sra_w[3'(7 - bitn_r)])
      else $error("start address byte wrong");
   AST_LOAD_FLAG: assert property (reg_addr_in == ihc_pkg::OFS_STATUS |=>
      reg_rdata_out[ihc_pkg::ILD_BIT] == $past(init_load_done_in)) else $error("flag wrong");
   AST_RDAT_HOLD: assert property (!rx_done_w |=> $stable(rdat_r))
      else $error("read data changed without a read");
endmodule

// ===== hw/ihc_pkg.sv
// Package for the host bus controller: register offsets, field positions,
// reset values, write masks, states and timing counts.
// Assumes a 250 MHz device clock and a register port of the device itself.
package ihc_pkg;
   // ----------------------------------------------------------------------
   // Register offsets, reset values and writable bits
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_HOST_CTRL = 8'h01;
   localparam logic [7:0] OFS_TS_CFG = 8'h02;
   localparam logic [7:0] OFS_STATUS = 8'h03;
   localparam logic [23:0] RST_HOST_CTRL = 24'h120140;
   localparam logic [23:0] RST_TS_CFG = 24'h92a4c8;
   localparam logic [23:0] RST_STATUS = 24'h800000;
   localparam logic [23:0] WMASK_HOST_CTRL = 24'h3e01fe;
   localparam logic [23:0] WMASK_TS_CFG = 24'hffffff;
   localparam logic [23:0] WMASK_STATUS = 24'hc3fe00;
   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int RW_LSB = 20;
   localparam int EN_BIT = 19;
   localparam int TRIG_BIT = 18;
   localparam int PSEL_BIT = 17;
   localparam int EEP_LSB = 2;
   localparam int SWAP_BIT = 1;
   localparam int TAVG_LSB = 22;
   localparam int TREN_BIT = 21;
   localparam int TS2_LSB = 14;
   localparam int TS1_LSB = 7;
   localparam int TS0_LSB = 0;
   localparam int MAVG_LSB = 22;
   localparam int NTRAN_BIT = 17;
   localparam int SRA_LSB = 9;
   localparam int ILD_BIT = 8;
   localparam int RDAT_LSB = 0;
   // ----------------------------------------------------------------------
   // Averaging modes, states and timing
   // ----------------------------------------------------------------------
   localparam logic [1:0] AVG_NONE = 2'h0;
   localparam logic [1:0] AVG_TWO = 2'h1;
   localparam logic [1:0] AVG_FOUR = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_START = 4'h2,
      ST_BYTE = 4'h4,
      ST_STOP = 4'h8
   } ihc_state_t;
   localparam int CLK_NS = 4;
   localparam int QTR_NS = 625;
   localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== tb/ihc_slave_model.sv
// Behavioural model of the external memory and temperature sensor slaves.
// Assumes resolved open-drain wires with pull-ups; it acknowledges any address.
`timescale 1ns/1ps

module ihc_slave_model (
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [7:0] rd_byte_in,
   output logic sda_oe_out,
   output logic [7:0] addr_seen_out,
   output logic [7:0] data_seen_out,
   output logic [7:0] n_start_out
);
   logic [7:0] sh_r = 8'h00;
   int bits = 0;
   logic active = 1'b0;
   logic in_addr = 1'b0;
   logic rd = 1'b0;

   // Nothing is pulled and nothing has been seen at time zero.
   initial begin
      sda_oe_out = 1'b0;
      addr_seen_out = 8'h00;
      data_seen_out = 8'h00;
      n_start_out = 8'h00;
   end

   // A start is the data line falling while the clock is high.
   always @(negedge sda_in) begin
      if (scl_in === 1'b1) begin
         active = 1'b1;
         in_addr = 1'b1;
         bits = -1;
         n_start_out = n_start_out + 8'h01;
      end
   end

   // A stop is the data line rising while the clock is high.
   always @(posedge sda_in) begin
      if (scl_in === 1'b1) begin
         active = 1'b0;
      end
   end

   // Bits are taken on the rising clock, most significant first.
   always @(posedge scl_in) begin
      if (active && bits < 8) begin
         sh_r = {sh_r[6:0], sda_in};
      end
   end

   // Acknowledge and read data change only while the clock is low.
   // The line is let go after a read byte so the host can end it with a stop.
   always @(negedge scl_in) begin
      if (active) begin
         bits = bits + 1;
         if (bits == 8 && in_addr) begin
            addr_seen_out = sh_r;
            rd = sh_r[0];
         end
         if (bits == 8 && !in_addr && !rd) begin
            data_seen_out = sh_r;
         end
         if (bits == 9) begin
            bits = 0;
            active = in_addr;
            in_addr = 1'b0;
         end
         sda_oe_out = active && ((in_addr || !rd) ? (bits == 8) :
                      (bits < 8 && !rd_byte_in[7 - bits]));
      end
   end
endmodule

// ===== tb/tb.sv
// Self-checking bench of the host bus controller with a slave model.
// Assumes a 4 ns clock and a shortened quarter-bit count of four cycles.
`timescale 1ns/1ps

`define CHK(a, b) begin \
   checked++; \
   if ((a) !== (b)) begin \
      n_mismatch++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); \
   end \
end

module tb;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic reg_wr_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [23:0] reg_wdata_in = 24'h000000;
   logic sample_start_in = 1'b0;
   logic [1:0] emitter_channel_in = 2'h0;
   logic init_load_done_in = 1'b0;
   logic onchip_temp_valid_in = 1'b0;
   logic [7:0] onchip_temp_in = 8'h00;
   logic [7:0] rd_byte = 8'h00;
   logic [23:0] reg_rdata_out;
   logic scl_oe_out, sda_oe_out, host_busy_out, host_nack_out, slv_oe;
   logic [7:0] ext_temp_avg_out, onchip_temp_avg_out, addr_seen, data_seen, n_start;
   logic [23:0] v;
   int n_mismatch = 0;
   int checked = 0;
   // Open-drain wires with pull-ups: low while any party pulls.
   wire logic sda_w = !(sda_oe_out || slv_oe);
   wire logic scl_w = !scl_oe_out;

   ihc_host_ctrl #(.QTR_CYC(4)) u_ihc_host_ctrl (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .sample_start_in(sample_start_in), .emitter_channel_in(emitter_channel_in),
      .init_load_done_in(init_load_done_in), .onchip_temp_valid_in(onchip_temp_valid_in),
      .onchip_temp_in(onchip_temp_in), .sda_in(sda_w), .scl_out(), .scl_oe_out(scl_oe_out),
      .sda_out(), .sda_oe_out(sda_oe_out), .ext_temp_avg_out(ext_temp_avg_out),
      .onchip_temp_avg_out(onchip_temp_avg_out), .host_busy_out(host_busy_out),
      .host_nack_out(host_nack_out));
   ihc_slave_model u_ihc_slave_model (.scl_in(scl_w), .sda_in(sda_w), .rd_byte_in(rd_byte),
      .sda_oe_out(slv_oe), .addr_seen_out(addr_seen), .data_seen_out(data_seen),
      .n_start_out(n_start));

   // Free-running 250 MHz clock.
   always #2 ref_clk_in = ~ref_clk_in;

   // -----------------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------------
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [23:0] ctl(input logic [1:0] rwv, input logic en,
                                       input logic trig, input logic psel,
                                       input logic [6:0] ea, input logic sw);
      return {2'h0, rwv, en, trig, psel, 8'h00, ea, sw, 1'b0};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [23:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      #1;
      d = reg_rdata_out;
   endtask
   task automatic pulse_sample();
      @(posedge ref_clk_in);
      sample_start_in <= 1'b1;
      @(posedge ref_clk_in);
      sample_start_in <= 1'b0;
   endtask
   // Waits for the engine to go busy and then stay idle for 40 cycles.
   task automatic host_done();
      int low;
      logic seen;
      low = 0;
      seen = 1'b0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge ref_clk_in);
         #1;
         if (host_busy_out === 1'b1) begin
            seen = 1'b1;
            low = 0;
         end else if (seen) begin
            low++;
         end
         if (low == 40) return;
      end
      n_mismatch++;
      wrap_up();
   endtask
   task automatic feed(input logic [7:0] t);
      @(posedge ref_clk_in);
      onchip_temp_in <= t;
      onchip_temp_valid_in <= 1'b1;
      @(posedge ref_clk_in);
      onchip_temp_valid_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
   endtask

   // -----------------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------------
   task automatic t_regs();
      rd(8'h01, v);
      `CHK(v, 24'h120140)
      rd(8'h02, v);
      `CHK(v, 24'h92a4c8)
      rd(8'h03, v);
      `CHK(v, 24'h800000)
      @(posedge ref_clk_in);
      init_load_done_in <= 1'b1;
      rd(8'h03, v);
      `CHK(v, 24'h800100)
      wr(8'h04, 24'hffffff);
      rd(8'h04, v);
      `CHK(v, 24'h000000)
      wr(8'h01, 24'hf301ff);
      rd(8'h01, v);
      `CHK(v, 24'h3201fe)
      wr(8'h02, 24'hffffff);
      rd(8'h02, v);
      `CHK(v, 24'hffffff)
      wr(8'h03, 24'hffffff);
      rd(8'h03, v);
      `CHK(v, 24'hc3ff00)
      wr(8'h02, 24'h92a4c8);
      wr(8'h03, 24'h000000);
   endtask
   task automatic t_quiet();
      int hits;
      logic [7:0] n0;
      hits = 0;
      n0 = n_start;
      for (int ph = 0; ph < 2; ph++) begin
         wr(8'h01, ctl(2'h1, ph == 1, 1'b0, ph == 0, 7'h50, 1'b0));
         pulse_sample();
         repeat (80) begin
            @(posedge ref_clk_in);
            if (host_busy_out !== 1'b0 || scl_oe_out !== 1'b0) hits++;
         end
      end
      `CHK(hits, 0)
      `CHK(n_start, n0)
   endtask
   task automatic t_mem_read(input logic sw, input logic [7:0] b, input logic [7:0] e);
      @(posedge ref_clk_in);
      rd_byte <= b;
      wr(8'h01, ctl(2'h1, 1'b1, 1'b1, 1'b0, 7'h50, sw));
      host_done();
      `CHK(addr_seen, 8'ha1)
      `CHK(host_nack_out, 1'b0)
      rd(8'h03, v);
      `CHK(v[7:0], e)
      rd(8'h01, v);
      `CHK(v[18], 1'b0)
   endtask
   task automatic t_two_tran();
      logic [7:0] n0;
      n0 = n_start;
      wr(8'h03, 24'h02b400);
      wr(8'h01, ctl(2'h2, 1'b1, 1'b1, 1'b0, 7'h50, 1'b0));
      host_done();
      `CHK(n_start - n0, 8'h02)
      `CHK(data_seen, 8'h5a)
      `CHK(addr_seen, 8'ha1)
      wr(8'h03, 24'h000000);
   endtask
   task automatic t_sensor();
      wr(8'h02, {2'h0, 1'b1, 7'h4a, 7'h49, 7'h48});
      wr(8'h01, ctl(2'h1, 1'b1, 1'b0, 1'b1, 7'h50, 1'b0));
      for (int ch = 0; ch < 3; ch++) begin
         @(posedge ref_clk_in);
         emitter_channel_in <= 2'(ch);
         rd_byte <= 8'h11 + 8'(ch * 5);
         pulse_sample();
         host_done();
         `CHK(addr_seen, {7'h48 + 7'(ch), 1'b1})
         `CHK(ext_temp_avg_out, 8'h11 + 8'(ch * 5))
      end
      wr(8'h02, {2'h1, 1'b1, 7'h4a, 7'h49, 7'h48});
      rd_byte <= 8'h2d;
      pulse_sample();
      host_done();
      `CHK(ext_temp_avg_out, 8'h24)
   endtask
   task automatic t_onchip();
      logic [1:0] md [3] = '{2'h1, 2'h0, 2'h3};
      logic [7:0] tv [3] = '{8'h40, 8'h07, 8'h09};
      logic [7:0] ev [3] = '{8'h34, 8'h07, 8'h09};
      wr(8'h03, 24'h800000);
      feed(8'h0a);
      feed(8'h14);
      feed(8'h1e);
      feed(8'h29);
      `CHK(onchip_temp_avg_out, 8'h19)
      for (int k = 0; k < 3; k++) begin
         wr(8'h03, {md[k], 22'h000000});
         feed(tv[k]);
         `CHK(onchip_temp_avg_out, ev[k])
      end
   endtask

   // Main sequence: reset for six cycles, then every scenario in turn.
   initial begin
      repeat (6) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      t_regs();
      t_quiet();
      t_mem_read(1'b0, 8'h1c, 8'h1c);
      t_mem_read(1'b1, 8'h1c, 8'h38);
      t_two_tran();
      t_sensor();
      t_onchip();
      wrap_up();
   end
endmodule
